// *** testbench/scr_regs_sva.sv ***
// Concurrent checks on the ports of the system control register bank.
module scr_regs_sva
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire scr_pkg::scr_core_s core,
    input wire logic nonmaskable_pending,
    input wire logic deferred_call_pending,
    input wire logic tick_pending,
    input wire logic [31:0] table_base_offset,
    input wire logic table_region_select,
    input wire logic [8:0] active_line_index,
    input wire logic active_line_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Address phase decode.
    logic take;
    logic rd_id;
    logic rd_ics;
    logic wr_ics;
    logic wr_vto;
    assign take = hsel && htrans[1] && hready;
    assign rd_id = take && !hwrite && haddr[11:0] == scr_pkg::OFS_ID;
    assign rd_ics = take && !hwrite && haddr[11:0] == scr_pkg::OFS_ICS;

    // Flags mark the data phase of a control word or offset write.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_ics <= 1'b0;
            wr_vto <= 1'b0;
        end
        else
        begin
            wr_ics <= take && hwrite && haddr[11:0] == scr_pkg::OFS_ICS;
            wr_vto <= take && hwrite && haddr[11:0] == scr_pkg::OFS_VTO;
        end
    end

    // ==========================================================
    // Assertions.
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    id_word_a: assert property (rd_id |=> hrdata == {scr_pkg::ID_IMPL,
        scr_pkg::ID_VARIANT, scr_pkg::ID_CONST, scr_pkg::ID_PART,
        scr_pkg::ID_REV}) else $error("identification word wrong");
    nmi_set_a: assert property ((wr_ics && hwdata[31]) ||
        core.nmi_request |=> nonmaskable_pending)
        else $error("nonmaskable pending not set");
    nmi_entry_a: assert property (core.nmi_entry &&
        !core.nmi_request && !(wr_ics && hwdata[31])
        |=> !nonmaskable_pending) else $error("nonmaskable not cleared");
    call_only_a: assert property ($rose(deferred_call_pending)
        |-> $past(wr_ics && hwdata[28])) else $error("call pended alone");
    call_clear_a: assert property (wr_ics && hwdata[27] &&
        !hwdata[28] |=> !deferred_call_pending)
        else $error("call pending not cleared");
    tick_set_a: assert property ((wr_ics && hwdata[26]) ||
        core.tick_event |=> tick_pending) else $error("tick not pended");
    tick_clear_a: assert property (wr_ics && hwdata[25] &&
        !hwdata[26] && !core.tick_event |=> !tick_pending)
        else $error("tick pending not cleared");
    status_read_a: assert property (rd_ics |=>
        hrdata[23] == $past(core.debug_state && core.debug_view) &&
        hrdata[11] == !$past(core.preempted_active) &&
        hrdata[8:0] == ($past(core.thread_mode) ? 9'h000 :
        $past(core.active_number))) else $error("status read wrong");
    line_index_a: assert property (!core.thread_mode &&
        core.active_number >= 9'h010 |=> active_line_valid &&
        active_line_index == $past(core.active_number) - 9'h010)
        else $error("line index wrong");
    offset_store_a: assert property (wr_vto |=>
        table_base_offset == {2'b00, $past(hwdata[29:9]), 9'h000})
        else $error("table offset not stored");
    region_sel_a: assert property (table_region_select ==
        table_base_offset[29]) else $error("region select wrong");
endmodule

bind scr_regs scr_regs_sva u_sva (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hwdata, .hready, .hrdata, .core,
    .nonmaskable_pending, .deferred_call_pending, .tick_pending,
    .table_base_offset, .table_region_select, .active_line_index,
    .active_line_valid);

// *** testbench/testbench.sv ***
// Self-checking testbench of the system control register bank.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    scr_pkg::scr_core_s core;
    logic nmi_o;
    logic dc_o;
    logic tk_o;
    logic [31:0] tbo;
    logic trs;
    logic [8:0] ali;
    logic alv;
    logic nmi_p;
    logic dc_p;
    logic tk_p;
    logic [31:0] seed = 32'h0000_7bd3;
    logic [31:0] rd;
    logic [31:0] w;
    int miscompares;
    int num_checks;
    int cycles;

    scr_regs DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .core(core),
        .nonmaskable_pending(nmi_o), .deferred_call_pending(dc_o),
        .tick_pending(tk_o), .table_base_offset(tbo),
        .table_region_select(trs), .active_line_index(ali),
        .active_line_valid(alv));

    // ==========================================================
    // Clock, timeout and helpers.
    initial
    begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    // Cuts a hang short after far more cycles than the tests need.
    initial
    begin
        forever
        begin
            @(posedge hclk);
            cycles++;
            if (cycles == 5000)
            begin
                miscompares++;
                final_report();
            end
        end
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Expected control word from the pending model and core status.
    function automatic logic [31:0] ics_exp();
        logic m;
        logic [31:0] v;
        m = !core.pend_fixed && (core.fault_mask_a ||
            (core.base_priority_mask != 8'h00 &&
            core.pend_priority >= core.base_priority_mask));
        v = 32'h0000_0000;
        v[31] = nmi_p;
        v[28] = dc_p;
        v[26] = tk_p;
        v[23] = core.debug_state && core.debug_view;
        v[22] = core.any_irq_pending;
        v[18:12] = m ? 7'h00 : core.pend_number;
        v[11] = !core.preempted_active;
        v[8:0] = core.thread_mode ? 9'h000 : core.active_number;
        return v;
    endfunction

    task automatic check(input string n, input logic [31:0] s, e);
        num_checks++;
        if (s !== e)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask

    // One single word transfer; entered just after a rising edge.
    task automatic bus(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {20'h00000, a};
        hwrite <= wr;
        hsize <= 3'b010;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
        check("response", {31'h0, hresp}, 32'h0000_0000);
    endtask

    // Fresh random core status, then control word and outputs compared.
    task automatic ics_chk();
        logic [31:0] r;
        r = xs();
        core <= scr_pkg::scr_core_s'({5'h00, r[6:0], xs()});
        bus(1'b0, scr_pkg::OFS_ICS, xs(), rd);
        check("control word", rd, ics_exp());
        check("pend flags", {nmi_o, dc_o, tk_o}, {nmi_p, dc_p, tk_p});
        r = {23'h0, core.active_number} - 32'h0000_0010;
        w[0] = !core.thread_mode && core.active_number >= 9'h010;
        check("line index", {alv, ali}, {w[0], w[0] ? r[8:0] : 9'h0});
    endtask

    // Pulses core event bits for one cycle.
    task automatic pulse(input logic [4:0] m);
        @(posedge hclk);
        core <= scr_pkg::scr_core_s'({m, core[38:0]});
        @(posedge hclk);
        core <= scr_pkg::scr_core_s'({5'h00, core[38:0]});
    endtask

    task automatic final_report();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ==========================================================
    // Main sequence.
    initial
    begin
        {hresetn, hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
        {nmi_p, dc_p, tk_p} = 3'b000;
        core = scr_pkg::scr_core_s'(44'h0);
        core.preempted_active = 1'b1;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, scr_pkg::OFS_ICS, 32'h0, rd);
        check("control reset", rd, 32'h0000_0000);
        bus(1'b0, scr_pkg::OFS_VTO, 32'h0, rd);
        check("offset reset", rd, 32'h0000_0000);
        bus(1'b1, scr_pkg::OFS_ID, xs(), rd);
        bus(1'b0, scr_pkg::OFS_ID, 32'h0, rd);
        w = {scr_pkg::ID_IMPL, scr_pkg::ID_VARIANT, scr_pkg::ID_CONST,
            scr_pkg::ID_PART, scr_pkg::ID_REV};
        check("id word", rd, w);
        bus(1'b1, 12'h00c, xs(), rd);
        bus(1'b0, 12'h00c, 32'h0, rd);
        check("unmapped", rd, 32'h0000_0000);
        repeat (8)
        begin
            w = xs();
            bus(1'b1, scr_pkg::OFS_VTO, w, rd);
            bus(1'b0, scr_pkg::OFS_VTO, 32'h0, rd);
            check("offset", rd, w & 32'h3fff_fe00);
            check("offset out", tbo, w & 32'h3fff_fe00);
            check("region", {31'h0, trs}, {31'h0, w[29]});
        end
        for (int k = 0; k < 16; k++)
        begin
            w = xs() & 32'h00ff_ffff;
            w[k < 8 ? 28 : 26] = k % 4 == 0;
            w[k < 8 ? 27 : 25] = k % 4 == 2;
            bus(1'b1, scr_pkg::OFS_ICS, w, rd);
            if (k % 4 != 1 && k % 4 != 3 && k < 8)
                dc_p = k % 4 == 0;
            if (k % 4 != 1 && k % 4 != 3 && k >= 8)
                tk_p = k % 4 == 0;
            ics_chk();
        end
        bus(1'b1, scr_pkg::OFS_ICS, 32'h8000_0000, rd);
        nmi_p = 1'b1;
        ics_chk();
        pulse(5'b01000);
        nmi_p = 1'b0;
        ics_chk();
        pulse(5'b11000);
        nmi_p = 1'b1;
        ics_chk();
        pulse(5'b01010);
        {nmi_p, tk_p} = 2'b01;
        ics_chk();
        pulse(5'b00001);
        tk_p = 1'b0;
        ics_chk();
        // Deferred call pended by a write, then cleared by handler entry.
        bus(1'b1, scr_pkg::OFS_ICS, 32'h1000_0000, rd);
        dc_p = 1'b1;
        ics_chk();
        pulse(5'b00100);
        dc_p = 1'b0;
        ics_chk();
        // Aligned offset in the SRAM region and two pending flags set.
        bus(1'b1, scr_pkg::OFS_VTO, 32'h2000_0200, rd);
        bus(1'b1, scr_pkg::OFS_ICS, 32'h1400_0000, rd);
        check("region set", {31'h0, trs}, 32'h0000_0001);
        {dc_p, tk_p} = 2'b11;
        ics_chk();
        // A reset in mid-run must bring both registers back to zero.
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        {nmi_p, dc_p, tk_p} = 3'b000;
        @(posedge hclk);
        check("offset out reset", tbo, 32'h0000_0000);
        ics_chk();
        bus(1'b0, scr_pkg::OFS_VTO, 32'h0, rd);
        check("offset reset again", rd, 32'h0000_0000);
        final_report();
    end
endmodule

// *** verilog/scr_ahb_slave.sv ***
// AHB-Lite slave front end: address phase capture, zero wait states.
module scr_ahb_slave
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output scr_pkg::scr_acc_s acc
);

    // ==========================================================
    // State of the data phase.
    typedef struct packed {
        logic wr;
        logic [11:0] wr_addr;
        logic readyout;
        logic resp;
    } scr_ahb_s;

    scr_ahb_s st;
    scr_ahb_s next_st;
    logic take;

    // A transfer starts on NONSEQ or SEQ while the bus is ready.
    assign take = hsel & htrans[1] & hready;

    // Latch writes for their data phase; always OKAY, never wait.
    always_comb
    begin
        next_st = st;
        next_st.wr = take & hwrite;
        next_st.wr_addr = haddr[11:0];
        next_st.readyout = 1'b1;
        next_st.resp = 1'b0;
    end

    // Register the data phase.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st <= '{wr: 1'b0, wr_addr: 12'h000, readyout: 1'b1, resp: 1'b0};
        else
            st <= next_st;
    end

    // Reads are decoded in the address phase, writes in the data phase.
    assign acc.rd = take & ~hwrite;
    assign acc.rd_addr = haddr[11:0];
    assign acc.wr = st.wr;
    assign acc.wr_addr = st.wr_addr;
    assign hreadyout = st.readyout;
    assign hresp = st.resp;

endmodule

// *** verilog/scr_pend_flag.sv ***
// Sticky pending flag in which a set beats a simultaneous clear.
module scr_pend_flag
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic set_req,
    input wire logic clr_req,
    output logic pending,
    output logic next_pending
);

    // ==========================================================
    // State update.
    typedef struct packed {
        logic pending;
    } scr_flag_s;

    scr_flag_s st;
    scr_flag_s next_st;

    // A set in the clearing cycle keeps the flag high.
    always_comb
    begin
        next_st = st;
        next_st.pending = set_req | (st.pending & ~clr_req);
    end

    // Register the flag.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st <= '0;
        else
            st <= next_st;
    end

    assign pending = st.pending;
    assign next_pending = next_st.pending;

endmodule

// *** verilog/scr_pkg.sv ***
// Constants, field layouts and carrier types of the system control registers.
// Operation
// - Identification word read-only with five fields.
// - Nonmaskable set bit pends; reads pending state.
// - Nonmaskable handler entry clears; re-assertion re-pends.
// - Deferred call set bit pends; only way.
// - Deferred call clear bit write-only, removes pending.
// - Tick set bit pends; reads pending state.
// - Tick clear bit write-only, removes pending.
// - Debug bit reads zero outside debug state.
// - Any-interrupt flag excludes nonmaskable and faults.
// - Pending number is highest enabled, else zero.
// - Pending number honours base and fault masks.
// - Return-to-base clear while preempted actives remain.
// - Active number follows program status; thread zero.
// - External line index is active number minus sixteen.
// - Table offset keeps bits 29:9, rest zero.
// - Offset bit 29 selects code or SRAM region.
// - Control word and table offset reset zero.
package scr_pkg;

    // ==========================================================
    // Register map, byte addresses within the block.
    localparam logic [11:0] OFS_ID = 12'h000;
    localparam logic [11:0] OFS_ICS = 12'h004;
    localparam logic [11:0] OFS_VTO = 12'h008;

    // ==========================================================
    // Identification fields; all default values are arbitrary.
    localparam logic [7:0] ID_IMPL = 8'h5a;
    localparam logic [3:0] ID_VARIANT = 4'h2;
    localparam logic [3:0] ID_CONST = 4'h7;
    localparam logic [11:0] ID_PART = 12'h5a3;
    localparam logic [3:0] ID_REV = 4'h2;

    // ==========================================================
    // Control word bit positions.
    localparam int B_NMI_SET = 31;
    localparam int B_DC_SET = 28;
    localparam int B_DC_CLR = 27;
    localparam int B_TK_SET = 26;
    localparam int B_TK_CLR = 25;
    localparam int B_DBG = 23;
    localparam int B_ANY = 22;
    localparam int B_PEND_LO = 12;
    localparam int B_RTB = 11;
    localparam int B_ACT_LO = 0;

    // ==========================================================
    // Table offset layout and reset values.
    localparam int B_VTO_LO = 9;
    localparam int B_VTO_REGION = 29;
    localparam logic [31:0] ICS_RESET = 32'h0000_0000;
    localparam logic [20:0] VTO_RESET = 21'h00_0000;
    localparam logic [8:0] EXT_LINE_BASE = 9'h010;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // ==========================================================
    // Status supplied by the exception prioritisation logic.
    typedef struct packed {
        logic nmi_request;
        logic nmi_entry;
        logic deferred_entry;
        logic tick_event;
        logic tick_entry;
        logic debug_state;
        logic debug_view;
        logic any_irq_pending;
        logic [6:0] pend_number;
        logic [7:0] pend_priority;
        logic pend_fixed;
        logic [7:0] base_priority_mask;
        logic fault_mask_a;
        logic preempted_active;
        logic thread_mode;
        logic [8:0] active_number;
    } scr_core_s;

    // Bus access as seen by the register file.
    typedef struct packed {
        logic rd;
        logic [11:0] rd_addr;
        logic wr;
        logic [11:0] wr_addr;
    } scr_acc_s;

endpackage

// *** verilog/scr_regs.sv ***
// Identification, interrupt control/state and table offset registers.
module scr_regs
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire scr_pkg::scr_core_s core,
    output logic nonmaskable_pending,
    output logic deferred_call_pending,
    output logic tick_pending,
    output logic [31:0] table_base_offset,
    output logic table_region_select,
    output logic [8:0] active_line_index,
    output logic active_line_valid
);

    // ==========================================================
    // Register state.
    typedef struct packed {
        logic [20:0] table_off;
        logic [31:0] rdata;
        logic [8:0] line_index;
        logic line_valid;
    } scr_regs_s;

    scr_regs_s st;
    scr_regs_s next_st;
    scr_pkg::scr_acc_s acc;
    logic ics_wr;
    logic nmi_set;
    logic nmi_now;
    logic nmi_next;
    logic dc_set;
    logic dc_clr;
    logic dc_now;
    logic dc_next;
    logic tk_set;
    logic tk_clr;
    logic tk_now;
    logic tk_next;
    logic [6:0] pend_view;
    logic [31:0] id_word;
    logic [31:0] ics_word;
    logic [31:0] vto_word;
    logic [20:0] next_table_off;

    // ==========================================================
    // Functions.

    // True when the register write targets the given offset.
    function automatic logic hit(input logic [11:0] addr,
                                 input logic [11:0] ofs);
        hit = (addr == ofs);
    endfunction

    // Masking of the pending exception by base priority and fault mask.
    // Fixed-priority exceptions are never masked; the primary priority
    // mask is deliberately not consulted.
    function automatic logic [6:0] masked_pending(
        input scr_pkg::scr_core_s c);
        logic blocked;
        blocked = 1'b0;
        if (!c.pend_fixed)
        begin
            if (c.fault_mask_a)
                blocked = 1'b1;
            else if (c.base_priority_mask != 8'h00 &&
                     c.pend_priority >= c.base_priority_mask)
                blocked = 1'b1;
        end
        masked_pending = blocked ? 7'h00 : c.pend_number;
    endfunction

    // Line index of an external interrupt, if the number is one.
    function automatic logic [8:0] line_of(input logic [8:0] num);
        line_of = num - scr_pkg::EXT_LINE_BASE;
    endfunction

    // ==========================================================
    // Bus front end.
    scr_ahb_slave u_bus
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .acc(acc)
    );

    // ==========================================================
    // Set and clear requests decoded from a control word write or from core events.
    // Zero bits have no effect; a write that sets and clears the same
    // exception at once leaves it pending.
    assign ics_wr = acc.wr & hit(acc.wr_addr, scr_pkg::OFS_ICS);
    assign nmi_set = (ics_wr & hwdata[scr_pkg::B_NMI_SET])
                     | core.nmi_request;
    assign dc_set = ics_wr & hwdata[scr_pkg::B_DC_SET];
    assign dc_clr = (ics_wr & hwdata[scr_pkg::B_DC_CLR])
                    | core.deferred_entry;
    assign tk_set = (ics_wr & hwdata[scr_pkg::B_TK_SET])
                    | core.tick_event;
    assign tk_clr = (ics_wr & hwdata[scr_pkg::B_TK_CLR])
                    | core.tick_entry;

    // ==========================================================
    // Pending flags of the three software-pendable exceptions.

    // Handler entry clears; a re-assertion in that cycle wins.
    scr_pend_flag u_nmi
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .set_req(nmi_set),
        .clr_req(core.nmi_entry),
        .pending(nmi_now),
        .next_pending(nmi_next)
    );

    // Set only by a register write.
    scr_pend_flag u_deferred
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .set_req(dc_set),
        .clr_req(dc_clr),
        .pending(dc_now),
        .next_pending(dc_next)
    );

    // Set by a write or by the tick timer.
    scr_pend_flag u_tick
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .set_req(tk_set),
        .clr_req(tk_clr),
        .pending(tk_now),
        .next_pending(tk_next)
    );

    // ==========================================================
    // Read words.

    // Identification word is built from constants only.
    assign id_word = {scr_pkg::ID_IMPL, scr_pkg::ID_VARIANT,
                      scr_pkg::ID_CONST, scr_pkg::ID_PART,
                      scr_pkg::ID_REV};

    assign pend_view = masked_pending(core);

    // Control word; write-only clear bits and reserved bits read zero.
    // Pending bits use next values so a read straight after a write
    // sees its effect.
    always_comb
    begin
        ics_word = scr_pkg::READ_ZERO;
        ics_word[scr_pkg::B_NMI_SET] = nmi_next;
        ics_word[scr_pkg::B_DC_SET] = dc_next;
        ics_word[scr_pkg::B_TK_SET] = tk_next;
        ics_word[scr_pkg::B_DBG] = core.debug_state
                                   & core.debug_view;
        ics_word[scr_pkg::B_ANY] = core.any_irq_pending;
        ics_word[scr_pkg::B_PEND_LO +: 7] = pend_view;
        ics_word[scr_pkg::B_RTB] = ~core.preempted_active;
        ics_word[scr_pkg::B_ACT_LO +: 9] = core.thread_mode ? 9'h000
                                         : core.active_number;
    end

    // Table offset word; low bits and top two bits read zero.
    // Offset after this cycle's write; the read path and the state share
    // it, so a read straight after a write sees the new value without a
    // loop through the next-state process.
    assign next_table_off = (acc.wr && hit(acc.wr_addr, scr_pkg::OFS_VTO))
        ? hwdata[scr_pkg::B_VTO_LO +: 21] : st.table_off;

    always_comb
    begin
        vto_word = scr_pkg::READ_ZERO;
        vto_word[scr_pkg::B_VTO_LO +: 21] = next_table_off;
    end

    // ==========================================================
    // Next state.
    always_comb
    begin
        next_st = st;
        // Only the offset bits of the table register are writable;
        // writes elsewhere change nothing.
        next_st.table_off = next_table_off;
        // Read data are captured at the end of the address phase.
        if (acc.rd)
        begin
            case (acc.rd_addr)
                scr_pkg::OFS_ID: next_st.rdata = id_word;
                scr_pkg::OFS_ICS: next_st.rdata = ics_word;
                scr_pkg::OFS_VTO: next_st.rdata = vto_word;
                default: next_st.rdata = scr_pkg::READ_ZERO;
            endcase
        end
        // External line index of the active exception, if external.
        next_st.line_valid = ~core.thread_mode
            && core.active_number >= scr_pkg::EXT_LINE_BASE;
        next_st.line_index = next_st.line_valid
            ? line_of(core.active_number) : 9'h000;
    end

    // ==========================================================
    // Register update; both architectural registers reset to zero.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st.table_off <= scr_pkg::VTO_RESET;
            st.rdata <= scr_pkg::ICS_RESET;
            st.line_index <= 9'h000;
            st.line_valid <= 1'b0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs, all straight from flip-flops.
    assign hrdata = st.rdata;
    assign nonmaskable_pending = nmi_now;
    assign deferred_call_pending = dc_now;
    assign tick_pending = tk_now;
    assign table_base_offset = {2'b00, st.table_off, 9'h000};
    assign table_region_select = st.table_off[20];
    assign active_line_index = st.line_index;
    assign active_line_valid = st.line_valid;

    // Size is not checked: only whole-word transfers are used.
    logic unused_size;
    assign unused_size = ^hsize;

endmodule
